// ==== design/osi_storage.sv ====
// scalar/address registers, local memory and instruction stack
`timescale 1ns/100ps
module osi_storage import osi_pkg::*; #(
   parameter int LM_WORDS = LM_BANK_WORDS,
   parameter int IQ_DEPTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // issue and results
   input wire osi_issue_s issue_in,
   input wire osi_result_s res_in,
   output logic [NREG-1:0] s_busy_out,
   output logic [NREG-1:0] a_busy_out,
   output logic [WP_W-1:0] wpath_rsv_out,
   // scalar operands
   output logic s_op_valid_out,
   output logic [S_W-1:0] s_opj_out,
   output logic [S_W-1:0] s_opk_out,
   output logic [S_W-1:0] s_hold_out,
   // address operands
   output logic a_op_valid_out,
   output logic [A_W-1:0] a_opj_out,
   output logic [A_W-1:0] a_opk_out,
   output logic [A_W-1:0] a_hold_out,
   // local memory
   input wire osi_lm_req_s lm_req_in,
   output logic lm_req_ready_out,
   output logic lm_wtake_out,
   input wire logic [S_W-1:0] lm_wdata_in,
   output logic lm_rvalid_out,
   output logic [S_W-1:0] lm_rdata_out,
   output logic lm_busy_out,
   output logic lm_perr_out,
   // branch
   input wire logic br_valid_in,
   input wire logic [CM_AW-1:0] br_addr_in,
   output logic br_ready_out,
   output logic br_hit_out,
   // common memory fetch
   output logic fr_valid_out,
   input wire logic fr_ready_in,
   output logic [CM_AW-1:0] fr_addr_out,
   output logic [2:0] fr_field_out,
   input wire osi_cm_word_s cm_in,
   // instruction words to issue queue
   output logic iw_valid_out,
   input wire logic iw_ready_in,
   output logic [S_W-1:0] iw_data_out,
   // stack errors
   output logic stk_perr_out,
   output logic [6:0] stk_err_addr_out
);
   // ---------------- scalar and address registers
   logic [S_W-1:0] sreg [NREG]; // scalar file
   logic [A_W-1:0] areg [NREG]; // address file
   logic [S_W-1:0] next_sreg [NREG];
   logic [A_W-1:0] next_areg [NREG];
   logic [NREG-1:0] next_s_busy, next_a_busy;
   logic [WP_W-1:0] next_wpath;
   logic [S_RD_DLY-1:0] s_pipe, next_s_pipe; // scalar read delay
   logic [2:0] s_j, s_k, next_s_j, next_s_k; // scalar source indices
   logic s_vs, next_s_vs; // vector-stream marker
   logic [S_W-1:0] next_s_opj, next_s_opk, next_s_hold;
   logic next_s_opv, next_a_opv;
   logic [A_W-1:0] next_a_opj, next_a_opk, next_a_hold;

   // reservation, write path and operand reads
   always_comb begin
      next_sreg = sreg;
      next_areg = areg;
      next_s_busy = s_busy_out;
      next_a_busy = a_busy_out;
      next_wpath = wpath_rsv_out >> 1;
      // single write path: store result, release destination
      if (res_in.valid) begin
         if (res_in.is_a) begin
            next_areg[res_in.idx] = res_in.data[A_W-1:0];
            next_a_busy[res_in.idx] = 1'b0;
         end else begin
            next_sreg[res_in.idx] = res_in.data;
            next_s_busy[res_in.idx] = 1'b0;
         end
      end
      // reservation set at issue wins over release
      if (issue_in.valid && issue_in.dst != DST_NONE) begin
         if (issue_in.dst == DST_S) next_s_busy[issue_in.di] = 1'b1;
         else next_a_busy[issue_in.di] = 1'b1;
         if (issue_in.wr_dly != 4'h0) next_wpath[issue_in.wr_dly - 4'h1] = 1'b1;
      end
      // scalar sources read a fixed delay after issue
      next_s_pipe = {s_pipe[S_RD_DLY-2:0], issue_in.valid && issue_in.rd_s};
      next_s_j = (issue_in.valid && issue_in.rd_s) ? issue_in.sj : s_j;
      next_s_k = (issue_in.valid && issue_in.rd_s) ? issue_in.sk : s_k;
      next_s_vs = (issue_in.valid && issue_in.rd_s) ? issue_in.vstream : s_vs;
      next_s_opv = s_pipe[S_RD_DLY-1];
      next_s_opj = s_pipe[S_RD_DLY-1] ? sreg[s_j] : s_opj_out;
      next_s_opk = s_pipe[S_RD_DLY-1] ? sreg[s_k] : s_opk_out;
      // streaming operand captured so the register is free
      next_s_hold = (s_pipe[S_RD_DLY-1] && s_vs) ? sreg[s_j] : s_hold_out;
      // address sources read the clock after issue
      next_a_opv = issue_in.valid && issue_in.rd_a;
      next_a_opj = next_a_opv ? areg[issue_in.sj] : a_opj_out;
      next_a_opk = next_a_opv ? areg[issue_in.sk] : a_opk_out;
      next_a_hold = (next_a_opv && issue_in.vstream) ? areg[issue_in.sj] : a_hold_out;
   end

   // register group state
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < NREG; i++) begin
            sreg[i] <= '0;
            areg[i] <= '0;
         end
         s_busy_out <= '0;
         a_busy_out <= '0;
         wpath_rsv_out <= '0;
         s_pipe <= '0;
         s_j <= '0;
         s_k <= '0;
         s_vs <= 1'b0;
         s_op_valid_out <= 1'b0;
         s_opj_out <= '0;
         s_opk_out <= '0;
         s_hold_out <= '0;
         a_op_valid_out <= 1'b0;
         a_opj_out <= '0;
         a_opk_out <= '0;
         a_hold_out <= '0;
      end else begin
         sreg <= next_sreg;
         areg <= next_areg;
         s_busy_out <= next_s_busy;
         a_busy_out <= next_a_busy;
         wpath_rsv_out <= next_wpath;
         s_pipe <= next_s_pipe;
         s_j <= next_s_j;
         s_k <= next_s_k;
         s_vs <= next_s_vs;
         s_op_valid_out <= next_s_opv;
         s_opj_out <= next_s_opj;
         s_opk_out <= next_s_opk;
         s_hold_out <= next_s_hold;
         a_op_valid_out <= next_a_opv;
         a_opj_out <= next_a_opj;
         a_opk_out <= next_a_opk;
         a_hold_out <= next_a_hold;
      end
   end

   // ---------------- local memory
   logic [S_W:0] lm_mem [LM_BANKS][LM_WORDS]; // parity + data per bank
   osi_lm_e lm_st, next_lm_st;
   logic [LM_AW-1:0] lm_addr, next_lm_addr; // running word address
   logic [6:0] lm_left, next_lm_left; // words still to move
   logic lm_wr, next_lm_wr;
   logic [6:0] lm_rsv, next_lm_rsv; // reservation countdown
   logic [LM_RD_DLY-1:0] lm_pv, next_lm_pv; // read pipe valid
   logic [LM_AW-1:0] lm_pa [LM_RD_DLY]; // read pipe address
   logic [LM_AW-1:0] next_lm_pa [LM_RD_DLY];
   logic lm_we, lm_rd;
   logic [LM_AW-1:0] lm_wa;
   logic [S_W-1:0] lm_wd;
   logic [S_W:0] lm_out;
   logic next_lm_rv, next_lm_perr;
   logic [S_W-1:0] next_lm_rdata;

   // sequencer, reservation and read pipe
   always_comb begin
      next_lm_st = lm_st;
      next_lm_addr = lm_addr;
      next_lm_left = lm_left;
      next_lm_wr = lm_wr;
      next_lm_rsv = (lm_rsv != '0) ? lm_rsv - 7'h01 : lm_rsv;
      lm_req_ready_out = (lm_rsv == '0) && (lm_st == LM_IDLE);
      lm_we = 1'b0;
      lm_rd = 1'b0;
      lm_wa = lm_addr;
      lm_wd = lm_wdata_in;
      lm_wtake_out = 1'b0;
      case (lm_st)
         LM_IDLE: begin
            if (lm_req_in.valid && lm_req_ready_out) begin
               if (lm_req_in.vector) begin
                  // reserve 10 clocks up to four words, one more each beyond
                  next_lm_rsv = (lm_req_in.vlen <= LM_VEC_KNEE) ? LM_RSV_VEC :
                     LM_RSV_VEC + lm_req_in.vlen - LM_VEC_KNEE;
                  next_lm_addr = lm_req_in.addr;
                  next_lm_left = lm_req_in.vlen;
                  next_lm_wr = lm_req_in.write;
                  next_lm_st = (lm_req_in.vlen != '0) ? LM_SETUP : LM_IDLE;
               end else begin
                  next_lm_rsv = LM_RSV_SCALAR;
                  lm_we = lm_req_in.write;
                  lm_rd = !lm_req_in.write;
                  lm_wa = lm_req_in.addr;
                  lm_wd = lm_req_in.data;
               end
            end
         end
         LM_SETUP: begin
            next_lm_st = LM_STREAM;
         end
         LM_STREAM: begin
            // one word per clock, address advancing
            lm_we = lm_wr;
            lm_rd = !lm_wr;
            lm_wtake_out = lm_wr;
            next_lm_addr = lm_addr + 14'h0001;
            next_lm_left = lm_left - 7'h01;
            if (lm_left == 7'h01) next_lm_st = LM_IDLE;
         end
         default: next_lm_st = LM_IDLE;
      endcase
      // read-out register samples bank a fixed delay later
      next_lm_pv = {lm_pv[LM_RD_DLY-2:0], lm_rd};
      next_lm_pa[0] = lm_wa;
      for (int i = 1; i < LM_RD_DLY; i++) next_lm_pa[i] = lm_pa[i-1];
      lm_out = lm_mem[lm_pa[LM_RD_DLY-1][1:0]][lm_pa[LM_RD_DLY-1][LM_AW-1:2]];
      next_lm_rv = lm_pv[LM_RD_DLY-1];
      next_lm_rdata = next_lm_rv ? lm_out[S_W-1:0] : lm_rdata_out;
      next_lm_perr = next_lm_rv && (lm_out[S_W] != ^lm_out[S_W-1:0]);
      lm_busy_out = (lm_rsv != '0);
   end

   // local memory state
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lm_st <= LM_IDLE;
         lm_addr <= '0;
         lm_left <= '0;
         lm_wr <= 1'b0;
         lm_rsv <= '0;
         lm_pv <= '0;
         for (int i = 0; i < LM_RD_DLY; i++) lm_pa[i] <= '0;
         lm_rvalid_out <= 1'b0;
         lm_rdata_out <= '0;
         lm_perr_out <= 1'b0;
      end else begin
         lm_st <= next_lm_st;
         lm_addr <= next_lm_addr;
         lm_left <= next_lm_left;
         lm_wr <= next_lm_wr;
         lm_rsv <= next_lm_rsv;
         lm_pv <= next_lm_pv;
         lm_pa <= next_lm_pa;
         lm_rvalid_out <= next_lm_rv;
         lm_rdata_out <= next_lm_rdata;
         lm_perr_out <= next_lm_perr;
      end
   end

   // bank write with parity generation
   always_ff @(posedge clk_in) begin
      if (lm_we) lm_mem[lm_wa[1:0]][lm_wa[LM_AW-1:2]] <= {^lm_wd, lm_wd};
   end

   // ---------------- instruction stack
   logic [S_W+1:0] stk_bank [2][STK_WORDS]; // tag, parity, data; 64 words per bank
   logic [CM_AW-1:0] fref [FIELDS]; // field reference addresses
   logic [CM_AW-1:0] next_fref [FIELDS];
   logic [FIELDS-1:0] fval, next_fval; // field-valid bits
   logic [2:0] oldest, next_oldest; // eviction pointer
   logic [2:0] rd_f, next_rd_f; // read field
   logic [3:0] rd_w, next_rd_w; // read word in field
   logic run, next_run; // reading enabled
   logic pf_done, next_pf_done; // prefetch checked for field
   logic next_fr_v;
   logic [CM_AW-1:0] next_fr_addr;
   logic [2:0] next_fr_f;
   logic next_perr, next_br_hit;
   logic [6:0] next_err_addr;
   logic br_m, nx_m; // match found
   logic [2:0] br_f, nx_f; // matching field
   logic [3:0] br_o, nx_o; // offset in field
   logic [S_W+1:0] rd_word;
   logic rd_conf, rd_cur, take, fi_ready, fetch_go;
   logic [CM_AW-1:0] nx_addr, fetch_addr;

   // all-field coincidence test, highest field wins
   function automatic void match(input logic [CM_AW-1:0] a, output logic m, output logic [2:0] f,
                        output logic [3:0] o);
      logic [CM_AW-1:0] d;
      m = 1'b0;
      f = '0;
      o = '0;
      for (int i = 0; i < FIELDS; i++) begin
         d = a - fref[i];
         if (d < CM_AW'(FIELD_WORDS)) begin
            m = 1'b1;
            f = 3'(i);
            o = d[3:0];
         end
      end
   endfunction : match

   // branch, read-out, prefetch and refill
   always_comb begin
      next_fref = fref;
      next_fval = fval;
      next_oldest = oldest;
      next_rd_f = rd_f;
      next_rd_w = rd_w;
      next_run = run;
      next_pf_done = pf_done;
      next_fr_v = fr_valid_out && !fr_ready_in;
      next_fr_addr = fr_addr_out;
      next_fr_f = fr_field_out;
      next_err_addr = stk_err_addr_out;
      next_br_hit = 1'b0;
      fetch_go = 1'b0;
      fetch_addr = br_addr_in;
      match(br_addr_in, br_m, br_f, br_o);
      nx_addr = fref[rd_f] + CM_AW'(FIELD_WORDS);
      match(nx_addr, nx_m, nx_f, nx_o);
      br_ready_out = !next_fr_v;
      // word at the read pointer; bank picked by word parity
      rd_word = stk_bank[rd_w[0]][{rd_f, rd_w[3:1]}];
      rd_conf = cm_in.valid && (cm_in.word[0] == rd_w[0]);
      rd_cur = (rd_word[S_W+1] == fval[rd_f]);
      take = run && !rd_conf && rd_cur && fi_ready && !br_valid_in;
      next_perr = take && (rd_word[S_W] != ^rd_word[S_W-1:0]);
      if (next_perr) next_err_addr = {rd_f, rd_w[3:1], rd_w[0]};
      if (br_valid_in && br_ready_out) begin
         next_run = 1'b1;
         next_pf_done = 1'b0;
         if (br_m) begin
            next_br_hit = 1'b1;
            next_rd_f = br_f;
            next_rd_w = br_o;
         end else begin
            fetch_go = 1'b1;
            next_rd_f = oldest;
            next_rd_w = '0;
         end
      end else if (take) begin
         // advance one word; cross into next field when present
         if (rd_w == 4'hf) begin
            next_rd_f = nx_f;
            next_rd_w = nx_o;
            next_run = nx_m;
            next_pf_done = 1'b0;
         end else begin
            next_rd_w = rd_w + 4'h1;
         end
      end else if (run && !nx_m && rd_w == 4'hf && !next_fr_v && pf_done) begin
         next_run = 1'b0; // next field lost, wait for a branch
      end
      // anticipate field end, fetch next sequential field
      if (!br_valid_in && run && !pf_done && rd_w >= PREFETCH_WORD && !next_fr_v) begin
         next_pf_done = 1'b1;
         if (!nx_m) begin
            fetch_go = 1'b1;
            fetch_addr = nx_addr;
         end
      end
      if (fetch_go) begin
         // evict oldest, toggle its bit, new reference address
         next_fval[oldest] = !fval[oldest];
         next_fref[oldest] = fetch_addr;
         next_oldest = oldest + 3'h1;
         next_fr_v = 1'b1;
         next_fr_addr = fetch_addr;
         next_fr_f = oldest;
      end
   end

   // stack control state
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < FIELDS; i++) fref[i] <= '1;
         fval <= '0;
         oldest <= '0;
         rd_f <= '0;
         rd_w <= '0;
         run <= 1'b0;
         pf_done <= 1'b0;
         fr_valid_out <= 1'b0;
         fr_addr_out <= '0;
         fr_field_out <= '0;
         stk_perr_out <= 1'b0;
         stk_err_addr_out <= '0;
         br_hit_out <= 1'b0;
      end else begin
         fref <= next_fref;
         fval <= next_fval;
         oldest <= next_oldest;
         rd_f <= next_rd_f;
         rd_w <= next_rd_w;
         run <= next_run;
         pf_done <= next_pf_done;
         fr_valid_out <= next_fr_v;
         fr_addr_out <= next_fr_addr;
         fr_field_out <= next_fr_f;
         stk_perr_out <= next_perr;
         stk_err_addr_out <= next_err_addr;
         br_hit_out <= next_br_hit;
      end
   end

   // refill word written with tag and parity, reset tags clear
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int b = 0; b < 2; b++)
            for (int i = 0; i < STK_WORDS; i++) stk_bank[b][i] <= '0;
      end else if (cm_in.valid) begin
         stk_bank[cm_in.word[0]][{cm_in.field, cm_in.word[3:1]}] <=
            {fval[cm_in.field], ^cm_in.data, cm_in.data};
      end
   end

   // issue queue buffer; full fifo stalls stack read-out
   osi_fifo #(.WIDTH(S_W), .DEPTH(IQ_DEPTH)) u_iq (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .flush_in(br_valid_in && br_ready_out),
      .in_valid_in(take),
      .in_ready_out(fi_ready),
      .in_data_in(rd_word[S_W-1:0]),
      .out_valid_out(iw_valid_out),
      .out_ready_in(iw_ready_in),
      .out_data_out(iw_data_out)
   );
endmodule : osi_storage

// ==== shared/osi_pkg.sv ====
// constants and carriers for the operand and instruction storage block
package osi_pkg;
   // register groups
   localparam int NREG = 8;
   localparam int RIDX_W = 3;
   localparam int S_W = 64;
   localparam int A_W = 32;
   // source read timing, phases and clocks
   localparam int S_RD_PHASE = 5;
   localparam int S_RD_DLY = (S_RD_PHASE + 1) / 2;
   localparam int A_RD_DLY = 1;
   localparam int WP_W = 16;
   // local memory geometry and timing
   localparam int LM_BANKS = 4;
   localparam int LM_BANK_WORDS = 4096;
   localparam int LM_AW = 14;
   localparam int LM_RD_DLY = 4;
   localparam logic [6:0] LM_RSV_SCALAR = 7'h05;
   localparam logic [6:0] LM_RSV_VEC = 7'h0a;
   localparam logic [6:0] LM_VEC_KNEE = 7'h04;
   // instruction stack geometry
   localparam int FIELDS = 8;
   localparam int FIELD_WORDS = 16;
   localparam int PARCELS_PER_WORD = 4;
   localparam int PREFETCH_PARCELS = 12;
   localparam logic [3:0] PREFETCH_WORD = 4'(FIELD_WORDS - PREFETCH_PARCELS / PARCELS_PER_WORD);
   localparam int STK_WORDS = 64;
   localparam int CM_AW = 24;
   // destination kinds, gray along none-scalar-address
   typedef enum logic [1:0] {DST_NONE = 2'b00, DST_S = 2'b01, DST_A = 2'b11} osi_dst_e;
   // local memory sequencer states
   typedef enum logic [1:0] {LM_IDLE = 2'b00, LM_SETUP = 2'b01, LM_STREAM = 2'b11} osi_lm_e;
   // one issued instruction
   typedef struct packed {
      logic valid;
      osi_dst_e dst;
      logic [2:0] di;
      logic [3:0] wr_dly;
      logic rd_s;
      logic rd_a;
      logic [2:0] sj;
      logic [2:0] sk;
      logic vstream;
   } osi_issue_s;
   // one result from a functional unit
   typedef struct packed {
      logic valid;
      logic is_a;
      logic [2:0] idx;
      logic [63:0] data;
   } osi_result_s;
   // one local memory reference
   typedef struct packed {
      logic valid;
      logic write;
      logic vector;
      logic [13:0] addr;
      logic [6:0] vlen;
      logic [63:0] data;
   } osi_lm_req_s;
   // one word returned from common memory
   typedef struct packed {
      logic valid;
      logic [2:0] field;
      logic [3:0] word;
      logic [63:0] data;
   } osi_cm_word_s;
endpackage : osi_pkg

// ==== design/osi_fifo.sv ====
// small flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module osi_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic flush_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [PW-1:0] wp, rp, next_wp, next_rp; // pointers
   logic [PW:0] cnt, next_cnt; // fill level
   logic push, pop;
   // handshakes
   always_comb begin
      in_ready_out = (cnt != (PW+1)'(DEPTH));
      out_valid_out = (cnt != '0);
      out_data_out = mem[rp];
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      next_wp = flush_in ? '0 : (push ? PW'((wp + 1'b1) % DEPTH) : wp);
      next_rp = flush_in ? '0 : (pop ? PW'((rp + 1'b1) % DEPTH) : rp);
      next_cnt = flush_in ? '0 : cnt + (PW+1)'(push) - (PW+1)'(pop);
   end
   // pointer registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end
   // storage write
   always_ff @(posedge clk_in) begin
      if (push && !flush_in) mem[wp] <= in_data_in;
   end
endmodule : osi_fifo

// ==== verif/osi_storage_monitor.sv ====
// port assertions for the storage block
`timescale 1ns/100ps
module osi_storage_monitor import osi_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // issue side
   input wire osi_issue_s issue_in,
   input wire logic [NREG-1:0] s_busy_out,
   input wire logic [NREG-1:0] a_busy_out,
   input wire logic [WP_W-1:0] wpath_rsv_out,
   input wire logic s_op_valid_out,
   input wire logic a_op_valid_out,
   // local memory and stack
   input wire osi_lm_req_s lm_req_in,
   input wire logic lm_req_ready_out,
   input wire logic lm_busy_out,
   input wire logic lm_rvalid_out,
   input wire logic br_valid_in,
   input wire logic br_ready_out,
   input wire logic br_hit_out,
   input wire logic fr_ready_in,
   input wire logic fr_valid_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // accepted non-vector local memory reference
   wire lm_go = lm_req_in.valid && lm_req_ready_out && !lm_req_in.vector;
   a_sdst_rsv: assert property (issue_in.valid && issue_in.dst == DST_S
      |=> s_busy_out[$past(issue_in.di)]) else $error("scalar dest not reserved");
   a_adst_rsv: assert property (issue_in.valid && issue_in.dst == DST_A
      |=> a_busy_out[$past(issue_in.di)]) else $error("address dest not reserved");
   a_wpath_slot: assert property (issue_in.valid && issue_in.dst != DST_NONE
      && issue_in.wr_dly != 4'h0 |=> wpath_rsv_out[$past(issue_in.wr_dly) - 1])
      else $error("write path slot missing");
   a_sread_late: assert property (issue_in.valid && issue_in.rd_s
      |-> ##4 s_op_valid_out) else $error("scalar operand late");
   a_aread_next: assert property (issue_in.valid && issue_in.rd_a
      |=> a_op_valid_out) else $error("address operand late");
   a_lm_rdlat: assert property (lm_go && !lm_req_in.write
      |-> ##5 lm_rvalid_out) else $error("local read latency");
   a_lm_hold5: assert property (lm_go |=> lm_busy_out [*5] ##1 !lm_busy_out)
      else $error("scalar reservation length");
   a_lm_refuse: assert property (lm_busy_out |-> !lm_req_ready_out)
      else $error("request taken while reserved");
   a_br_answer: assert property (br_valid_in && br_ready_out
      |=> br_hit_out || fr_valid_out) else $error("branch without answer");
   a_fetch_lock: assert property (fr_valid_out && !fr_ready_in |-> !br_ready_out)
      else $error("branch open during fetch");
   c_br_hit: cover property (br_hit_out);
   c_lm_vec: cover property (lm_req_in.valid && lm_req_in.vector && lm_req_ready_out);
   c_s_read: cover property (s_op_valid_out);
endmodule : osi_storage_monitor

bind osi_storage osi_storage_monitor i_mon (.*);

// ==== verif/osi_cm_model.sv ====
// common memory partner answering stack fetches
`timescale 1ns/100ps
module osi_cm_model import osi_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // fetch request
   input wire logic fr_valid_in,
   output logic fr_ready_out,
   input wire logic [CM_AW-1:0] fr_addr_in,
   input wire logic [2:0] fr_field_in,
   // pacing and word return
   input wire logic slow_in,
   output osi_cm_word_s cm_out
);
   logic [4:0] left; // words still owed
   logic [CM_AW-1:0] base; // first word address
   logic gap; // skip toggle in slow mode
   // one fetch at a time
   assign fr_ready_out = (left == 5'h00);
   // returns 16 sequential words, data equals word address
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         left <= 5'h00;
         gap <= 1'b0;
         base <= '0;
         cm_out <= '0;
      end else begin
         cm_out.valid <= 1'b0;
         cm_out.data <= ~cm_out.data; // idle bus never holds a word
         gap <= slow_in && !gap;
         if (fr_valid_in && fr_ready_out) begin
            left <= 5'h10;
            base <= fr_addr_in;
            cm_out.field <= fr_field_in;
         end else if (left != 5'h00 && !gap) begin
            cm_out.valid <= 1'b1;
            cm_out.word <= 4'(16 - left);
            cm_out.data <= {40'h0, base + 24'(16 - left)};
            left <= left - 5'h01;
         end
      end
   end
endmodule : osi_cm_model

// ==== verif/operand_and_instruction_storage_test.sv ====
// self-checking bench for the storage block
`timescale 1ns/100ps
module operand_and_instruction_storage_test import osi_pkg::*;;
   // stimulus
   logic clk_in = 1'b0, nrst_in = 1'b0, br_valid_in = 1'b0, iw_ready_in = 1'b0, slow = 1'b0;
   osi_issue_s issue_in = '0;
   osi_result_s res_in = '0;
   osi_lm_req_s lm_req_in = '0;
   logic [S_W-1:0] lm_wdata_in = 64'h0f0f_0f0f_0f0f_0f0f;
   logic [CM_AW-1:0] br_addr_in = '0;
   // observed outputs
   osi_cm_word_s cm_in;
   logic [NREG-1:0] s_busy_out, a_busy_out;
   logic [WP_W-1:0] wpath_rsv_out;
   logic s_op_valid_out, a_op_valid_out, lm_req_ready_out, lm_wtake_out, lm_rvalid_out;
   logic lm_busy_out, lm_perr_out, br_ready_out, br_hit_out, fr_valid_out, fr_ready_in;
   logic iw_valid_out, stk_perr_out;
   logic [S_W-1:0] s_opj_out, s_opk_out, s_hold_out, lm_rdata_out, iw_data_out;
   logic [A_W-1:0] a_opj_out, a_opk_out, a_hold_out;
   logic [CM_AW-1:0] fr_addr_out;
   logic [2:0] fr_field_out;
   logic [6:0] stk_err_addr_out;
   int n_fail = 0, checked = 0;
   always #5 clk_in = ~clk_in;
   osi_storage i_dut (.*);
   osi_cm_model i_cm (.clk_in(clk_in), .nrst_in(nrst_in), .fr_valid_in(fr_valid_out),
      .fr_ready_out(fr_ready_in), .fr_addr_in(fr_addr_out), .fr_field_in(fr_field_out),
      .slow_in(slow), .cm_out(cm_in));
   task give_verdict;
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step
   // bounded wait for a high level
   task automatic wait_hi(ref logic s);
      for (int k = 0; k < 300 && s !== 1'b1; k++) step(1);
      if (s !== 1'b1) begin
         n_fail++;
         give_verdict();
      end
   endtask : wait_hi
   // register writes, back-to-back issues, reads and release
   task t_regs;
      res_in = '{1'b1, 1'b0, 3'h1, 64'hdead_beef_0123_4567};
      step(1);
      res_in = '{1'b1, 1'b1, 3'h3, 64'h0000_0000_cafe_f00d};
      step(1);
      res_in.valid = 1'b0;
      issue_in = '{1'b1, DST_S, 3'h2, 4'h5, 1'b1, 1'b0, 3'h1, 3'h1, 1'b1};
      step(1);
      issue_in = '{1'b1, DST_A, 3'h4, 4'h2, 1'b0, 1'b1, 3'h3, 3'h3, 1'b0};
      step(1);
      issue_in.valid = 1'b0;
      chk(s_busy_out, 8'h04);
      chk(a_busy_out, 8'h10);
      chk(a_op_valid_out, 1'b1);
      chk(a_opj_out, 32'hcafe_f00d);
      chk(wpath_rsv_out, 16'h000a);
      step(2);
      chk(s_op_valid_out, 1'b1);
      chk(s_opk_out, 64'hdead_beef_0123_4567);
      chk(s_opj_out, 64'hdead_beef_0123_4567);
      chk(s_hold_out, 64'hdead_beef_0123_4567);
      res_in = '{1'b1, 1'b0, 3'h2, 64'h0};
      step(1);
      res_in = '{1'b1, 1'b1, 3'h4, 64'h0};
      step(1);
      res_in.valid = 1'b0;
      step(1);
      chk({s_busy_out, a_busy_out}, 16'h0000);
   endtask : t_regs
   // vector reference: count reservation, takes and returns
   task vec(input logic wr, input logic [6:0] len, input int exp_busy);
      int b;
      int t;
      b = 0;
      t = 0;
      lm_req_in = '{1'b1, wr, 1'b1, 14'h0003, len, 64'h0};
      wait_hi(lm_req_ready_out);
      step(1);
      lm_req_in.valid = 1'b0;
      for (int k = 0; k < 40; k++) begin
         b += lm_busy_out;
         t += wr ? lm_wtake_out : lm_rvalid_out;
         step(1);
      end
      chk(b, exp_busy);
      chk(t, len);
   endtask : vec
   task t_lmem;
      lm_req_in = '{1'b1, 1'b1, 1'b0, 14'h0006, 7'h00, 64'h1234_5678_9abc_def0};
      step(1);
      lm_req_in.write = 1'b0;
      chk(lm_req_ready_out, 1'b0);
      wait_hi(lm_req_ready_out);
      step(1);
      lm_req_in.valid = 1'b0;
      step(4);
      chk(lm_rvalid_out, 1'b1);
      chk(lm_rdata_out, 64'h1234_5678_9abc_def0);
      chk(lm_perr_out, 1'b0);
      vec(1'b1, 7'h06, 12);
      vec(1'b0, 7'h02, 10);
   endtask : t_lmem
   // miss with full buffer, drain in order, then a hit
   task t_stack;
      br_addr_in = 24'h0100;
      br_valid_in = 1'b1;
      wait_hi(br_ready_out);
      step(1);
      br_valid_in = 1'b0;
      chk(fr_addr_out, 24'h0100);
      chk(fr_field_out, 3'h0);
      step(40);
      slow = 1'b1;
      for (int k = 0; k < 12; k++) begin
         chk(iw_data_out, 64'h0100 + k);
         iw_ready_in = 1'b1;
         step(1);
      end
      step(80);
      br_valid_in = 1'b1;
      wait_hi(br_ready_out);
      step(1);
      br_valid_in = 1'b0;
      chk(br_hit_out, 1'b1);
      wait_hi(iw_valid_out);
      chk(iw_data_out, 64'h0100);
      chk(stk_perr_out, 1'b0);
      chk(stk_err_addr_out, 7'h00);
   endtask : t_stack
   initial begin
      step(20);
      nrst_in = 1'b1;
      t_regs();
      $display("registers test done");
      t_lmem();
      $display("local memory test done");
      t_stack();
      $display("stack test done");
      give_verdict();
   end
endmodule : operand_and_instruction_storage_test
